// *** common/rtpc_pkg.sv ***
/*
 * Package for the reloading timer with PWM and capture: register
 * offsets, field positions, reset values and carrier types.
 * Assumes an APB slave with 32-bit data, one byte register per word.
 */
package rtpc_pkg;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] RTPC_OFS_CNT_LO  = 8'h00;
    localparam logic [7:0] RTPC_OFS_CNT_HI  = 8'h04;
    localparam logic [7:0] RTPC_OFS_RLD_LO  = 8'h08;
    localparam logic [7:0] RTPC_OFS_RLD_HI  = 8'h0C;
    localparam logic [7:0] RTPC_OFS_CONFIG  = 8'h10;
    localparam logic [7:0] RTPC_OFS_FLAGS   = 8'h14;
    localparam logic [7:0] RTPC_OFS_IRQ_ACK = 8'h18;

    // ------------------------------------------------------------
    // Config register fields
    // ------------------------------------------------------------
    localparam int RTPC_CFG_RUN   = 4;
    localparam int RTPC_CFG_MODE5 = 5;
    localparam int RTPC_CFG_MODE6 = 6;
    localparam int RTPC_CFG_MODE7 = 7;

    // ------------------------------------------------------------
    // Flags register fields
    // ------------------------------------------------------------
    localparam int RTPC_FLG_GLOBAL_IRQ_ENABLE = 0;
    localparam int RTPC_FLG_PIN_IRQ_ENABLE    = 1;
    localparam int RTPC_FLG_TIMER_IRQ_ENABLE  = 4;
    localparam int RTPC_FLG_TIMER_IRQ_PENDING = 5;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  RTPC_CONFIG_RST = 8'h00;
    localparam logic [7:0]  RTPC_FLAGS_RST  = 8'h00;
    localparam logic [15:0] RTPC_CNT_RST    = 16'h0000;
    localparam logic [15:0] RTPC_RLD_RST    = 16'h0000;
    localparam logic [31:0] RTPC_ERR_DATA   = 32'h00000000;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } rtpc_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } rtpc_apb_rsp_t;

    typedef enum logic [2:0] {
        RTPC_MODE_EVENT   = 3'b001,
        RTPC_MODE_TIMER   = 3'b010,
        RTPC_MODE_CAPTURE = 3'b100
    } rtpc_mode_t;

endpackage

// *** core/rtpc_edge_detect.sv ***
/*
 * Edge detector for the timer pin: one-cycle pulse on the chosen edge.
 * Assumes the pin input is already synchronous to pclk.
 */
`timescale 1ns/1ps
`default_nettype none

module rtpc_edge_detect (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Pin and selection
    input  wire logic pin_in,
    input  wire logic falling_sel,
    // Result
    output logic      edge_pulse
);
    logic prev_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_ff <= 1'b0;
        end else begin
            prev_ff <= pin_in;
        end
    end

    assign edge_pulse = falling_sel ? (prev_ff & ~pin_in) : (~prev_ff & pin_in);
endmodule

`default_nettype wire

// *** core/rtpc_timer.sv ***
/*
 * Reloading timer/counter with PWM toggle, event count and input
 * capture, reached over APB as byte-wide registers.
 * Assumes pin input synchronous to pclk and a one-cycle
 * instruction-clock enable supplied from outside.
 */
// Overview of operation
// R1 - 16-bit counter and reload/capture register, each two read/write bytes.
// R2 - Timer modes count down each instruction cycle, reload on underflow.
// R3 - Reload value gives any division ratio 1 to 65536.
// R4 - Mode bits 7:5: 00x event, 01x forbidden, 10x timer, 11x capture.
// R5 - Timer mode with bit 5 set toggles the pin on each underflow.
// R6 - Event mode counts pin edges, reloading on underflow.
// R7 - Event mode bit 5: clear counts rising, set counts falling edges.
// R8 - External pin source stays at or below half the instruction rate.
// R9 - Capture mode counts cycles and copies counter on selected pin edge.
// R10 - Capture mode bit 5: clear captures rising, set captures falling.
// R11 - Timer event is capture edge or underflow, per mode.
// R12 - Run bit 4 lets the counter advance; clear holds it.
// R13 - Timer enable and pending bits govern the timer interrupt.
// R14 - Counter and reload registers are accessed one byte per transfer.
// R15 - Software should stop the counter before writing its bytes.
// R16 - Read high, low, then high again if low byte MSB is set.
// R17 - Global enable gates requests and clears on interrupt acknowledge.
// R18 - Each source needs its own enable and the global enable.
// R19 - Run bit one runs, zero stops.
// R20 - Pending bit set by underflow or capture edge as mode defines.
// R21 - Reset clears config and flags: stopped, event mode, no interrupts.
// R22 - Pending set on every event regardless of enables, software clears.
// R23 - Underflow is decrement from zero; reload replaces it, period N+1.
`timescale 1ns/1ps
`default_nettype none

module rtpc_timer
    import rtpc_pkg::*;
(
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire rtpc_pkg::rtpc_apb_req_t apb_req,
    output rtpc_pkg::rtpc_apb_rsp_t      apb_rsp,
    // Instruction-cycle enable
    input  wire logic              instruction_cycle_clock,
    // Timer pin (three signals)
    input  wire logic              timer_pin_in,
    output logic                   timer_pin_out,
    output logic                   timer_pin_oe,
    // External interrupt source and acknowledge
    input  wire logic              pin_irq_event,
    input  wire logic              irq_ack,
    // Interrupt requests
    output logic                   timer_irq_req,
    output logic                   pin_irq_req
);
    import rtpc_pkg::*;

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [7:0]  timer_serial_config_reg_ff;
    logic [7:0]  processor_flags_reg_ff;
    logic [15:0] count_ff;
    logic [15:0] reload_ff;
    logic        pin_out_ff;
    logic [31:0] prdata_ff;

    logic        counter_run_bit;
    logic        mode_select_bit7;
    logic        mode_select_bit6;
    logic        mode_select_bit5;
    logic        global_irq_enable;
    logic        pin_irq_enable;
    logic        timer_irq_enable;
    logic        timer_irq_pending;
    rtpc_mode_t  mode;

    assign counter_run_bit   = timer_serial_config_reg_ff[RTPC_CFG_RUN];     // [R19]
    assign mode_select_bit7  = timer_serial_config_reg_ff[RTPC_CFG_MODE7];
    assign mode_select_bit6  = timer_serial_config_reg_ff[RTPC_CFG_MODE6];
    assign mode_select_bit5  = timer_serial_config_reg_ff[RTPC_CFG_MODE5];
    assign global_irq_enable = processor_flags_reg_ff[RTPC_FLG_GLOBAL_IRQ_ENABLE];
    assign pin_irq_enable    = processor_flags_reg_ff[RTPC_FLG_PIN_IRQ_ENABLE];
    assign timer_irq_enable  = processor_flags_reg_ff[RTPC_FLG_TIMER_IRQ_ENABLE];
    assign timer_irq_pending = processor_flags_reg_ff[RTPC_FLG_TIMER_IRQ_PENDING];

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    // Forbidden 01x code counts nothing; software must not write it
    logic mode_legal;

    always_comb begin
        mode       = RTPC_MODE_EVENT;
        mode_legal = 1'b1;
        case ({mode_select_bit7, mode_select_bit6})   // [R4]
            2'b00: mode = RTPC_MODE_EVENT;
            2'b10: mode = RTPC_MODE_TIMER;
            2'b11: mode = RTPC_MODE_CAPTURE;
            default: mode_legal = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Pin edge selection
    // ------------------------------------------------------------
    logic pin_edge;

    rtpc_edge_detect u_edge (
        .pclk        (pclk),
        .presetn     (presetn),
        .pin_in      (timer_pin_in),
        .falling_sel (mode_select_bit5),                 // [R7] [R10]
        .edge_pulse  (pin_edge)
    );

    // ------------------------------------------------------------
    // Count source and events
    // ------------------------------------------------------------
    logic count_tick;
    logic underflow;
    logic capture_evt;
    logic timer_evt;

    always_comb begin
        count_tick = 1'b0;
        case (mode)
            RTPC_MODE_EVENT:   count_tick = pin_edge;                // [R6]
            RTPC_MODE_TIMER:   count_tick = instruction_cycle_clock; // [R2]
            RTPC_MODE_CAPTURE: count_tick = instruction_cycle_clock; // [R9]
            default:           count_tick = 1'b0;
        endcase
        count_tick = count_tick & counter_run_bit & mode_legal;       // [R12]
    end

    assign underflow   = count_tick && (count_ff == 16'h0000) &&
                         (mode != RTPC_MODE_CAPTURE);                 // [R23]
    // Capture edges are taken only while the counter runs
    assign capture_evt = (mode == RTPC_MODE_CAPTURE) && mode_legal &&
                         counter_run_bit && pin_edge;                 // [R9]
    assign timer_evt   = underflow | capture_evt;                     // [R11] [R20]

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    logic       acc;
    logic       wr;
    logic       rd;
    logic [7:0] wbyte;
    logic       addr_hit;

    assign acc   = apb_req.psel & apb_req.penable;
    assign wr    = acc & apb_req.pwrite;
    assign rd    = acc & ~apb_req.pwrite;
    assign wbyte = apb_req.pwdata[7:0];

    always_comb begin
        case (apb_req.paddr)
            RTPC_OFS_CNT_LO, RTPC_OFS_CNT_HI, RTPC_OFS_RLD_LO, RTPC_OFS_RLD_HI,
            RTPC_OFS_CONFIG, RTPC_OFS_FLAGS, RTPC_OFS_IRQ_ACK: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Config register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_serial_config_reg_ff <= RTPC_CONFIG_RST;              // [R21]
        end else if (wr && apb_req.paddr == RTPC_OFS_CONFIG) begin
            timer_serial_config_reg_ff <= wbyte;
        end
    end

    // ------------------------------------------------------------
    // Flags register
    // ------------------------------------------------------------
    logic [7:0] nxt_flags;

    always_comb begin
        nxt_flags = processor_flags_reg_ff;
        if (wr && apb_req.paddr == RTPC_OFS_FLAGS) begin
            nxt_flags = wbyte;                                          // [R22]
        end
        if (irq_ack) begin
            nxt_flags[RTPC_FLG_GLOBAL_IRQ_ENABLE] = 1'b0;               // [R17]
        end
        // Hardware set wins over a same-cycle software clear
        if (timer_evt) begin
            nxt_flags[RTPC_FLG_TIMER_IRQ_PENDING] = 1'b1;               // [R22] [R20]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            processor_flags_reg_ff <= RTPC_FLAGS_RST;                   // [R21]
        end else begin
            processor_flags_reg_ff <= nxt_flags;
        end
    end

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    // Byte writes land mid-count; stopping first avoids torn values
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_ff <= RTPC_CNT_RST;
        end else if (wr && apb_req.paddr == RTPC_OFS_CNT_LO) begin
            count_ff[7:0] <= wbyte;                                     // [R14] [R1]
        end else if (wr && apb_req.paddr == RTPC_OFS_CNT_HI) begin
            count_ff[15:8] <= wbyte;                                    // [R14] [R1]
        end else if (underflow) begin
            count_ff <= reload_ff;                                      // [R2] [R6] [R3]
        end else if (count_tick) begin
            count_ff <= count_ff - 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // Reload / capture register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reload_ff <= RTPC_RLD_RST;
        end else if (capture_evt) begin
            reload_ff <= count_ff;                                      // [R9]
        end else if (wr && apb_req.paddr == RTPC_OFS_RLD_LO) begin
            reload_ff[7:0] <= wbyte;                                    // [R14] [R1]
        end else if (wr && apb_req.paddr == RTPC_OFS_RLD_HI) begin
            reload_ff[15:8] <= wbyte;                                   // [R14] [R1]
        end
    end

    // ------------------------------------------------------------
    // Pin output
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out_ff <= 1'b0;
        end else if (underflow && mode == RTPC_MODE_TIMER && mode_select_bit5) begin
            pin_out_ff <= ~pin_out_ff;                                  // [R5]
        end
    end

    assign timer_pin_out = pin_out_ff;
    // Pin driven only in toggle mode; otherwise it is an input
    assign timer_pin_oe  = (mode == RTPC_MODE_TIMER) && mode_select_bit5; // [R5]

    // ------------------------------------------------------------
    // Interrupt requests
    // ------------------------------------------------------------
    assign timer_irq_req = global_irq_enable & timer_irq_enable & timer_irq_pending; // [R13] [R18]
    assign pin_irq_req   = global_irq_enable & pin_irq_enable & pin_irq_event;       // [R18]

    // ------------------------------------------------------------
    // APB read data
    // ------------------------------------------------------------
    logic [7:0] rbyte;

    always_comb begin
        case (apb_req.paddr)
            RTPC_OFS_CNT_LO: rbyte = count_ff[7:0];                     // [R14]
            RTPC_OFS_CNT_HI: rbyte = count_ff[15:8];
            RTPC_OFS_RLD_LO: rbyte = reload_ff[7:0];
            RTPC_OFS_RLD_HI: rbyte = reload_ff[15:8];
            RTPC_OFS_CONFIG: rbyte = timer_serial_config_reg_ff;
            RTPC_OFS_FLAGS:  rbyte = processor_flags_reg_ff;
            default:         rbyte = 8'h00;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= RTPC_ERR_DATA;
        end else if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
            prdata_ff <= {24'h000000, rbyte};
        end
    end

    // Zero-wait slave; unmapped addresses answer with pslverr
    assign apb_rsp.pready  = 1'b1;
    assign apb_rsp.pslverr = acc & ~addr_hit;
    assign apb_rsp.prdata  = rd ? prdata_ff : RTPC_ERR_DATA;

endmodule

`default_nettype wire

// *** verification/rtpc_timer_sva.sv ***
/* Port checker for rtpc_timer.
   Assumes it is bound to the top module; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module rtpc_timer_sva
    import rtpc_pkg::*;
(
    // Clock and reset
    input wire logic                    pclk,
    input wire logic                    presetn,
    // Watched ports
    input wire rtpc_pkg::rtpc_apb_req_t apb_req,
    input wire rtpc_pkg::rtpc_apb_rsp_t apb_rsp,
    input wire logic                    instruction_cycle_clock,
    input wire logic                    timer_pin_in,
    input wire logic                    timer_pin_out,
    input wire logic                    timer_pin_oe,
    input wire logic                    pin_irq_event,
    input wire logic                    irq_ack,
    input wire logic                    timer_irq_req,
    input wire logic                    pin_irq_req
);
    logic cfg_wr;
    logic flg_wr;
    assign cfg_wr = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.paddr == RTPC_OFS_CONFIG;
    assign flg_wr = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.paddr == RTPC_OFS_FLAGS;
    // Read access phase, and decoded word addresses
    logic rd_acc;
    logic mapped;
    assign rd_acc = apb_req.psel && apb_req.penable && !apb_req.pwrite;
    assign mapped = (apb_req.paddr <= RTPC_OFS_IRQ_ACK) && (apb_req.paddr[1:0] == 2'h0);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------
    sequence s_acc;
        apb_req.psel && apb_req.penable;
    endsequence
    sequence s_ack;
        irq_ack;
    endsequence
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    a_pready_high: assert property (s_acc |-> apb_rsp.pready)
        else $error("pready low in access phase");
    a_err_unmapped: assert property (s_acc ##0 !mapped |-> apb_rsp.pslverr)
        else $error("no error on unmapped address");
    a_ok_mapped: assert property (s_acc ##0 mapped |-> !apb_rsp.pslverr)
        else $error("error on mapped address");
    a_idle_prdata: assert property (!rd_acc |-> apb_rsp.prdata == 32'h0)
        else $error("read data outside read access");
    a_byte_prdata: assert property (apb_rsp.prdata[31:8] == 24'h0)
        else $error("upper read data bits set");
    a_oe_by_config: assert property ($changed(timer_pin_oe) |-> $past(cfg_wr))
        else $error("pin enable moved without config write");
    a_toggle_on_tick: assert property ($changed(timer_pin_out) |-> $past(instruction_cycle_clock && timer_pin_oe))
        else $error("pin toggled off an underflow tick");
    a_ack_masks: assert property (s_ack |=> !timer_irq_req && !pin_irq_req)
        else $error("request survived acknowledge");
    a_pin_req_src: assert property (pin_irq_req |-> pin_irq_event)
        else $error("pin request without event");
    a_irq_sticky: assert property ($fell(timer_irq_req) |-> $past(irq_ack || flg_wr))
        else $error("timer request dropped by itself");
endmodule
`default_nettype wire

// *** verification/rtpc_pin_source.sv ***
/* Signal source on the timer pin: a burst of level changes.
   Assumes the bench folds its level with the design's drive. */
`timescale 1ns/1ps
`default_nettype none
module rtpc_pin_source #(
    parameter int HALF = 8
) (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Burst request
    input  wire logic       start,
    input  wire logic [3:0] count,
    // Pin side
    output logic            pin_level,
    output logic            busy
);
    logic       level_ff;
    logic [3:0] left_ff;
    logic [7:0] gap_ff;
    // Half period of two instruction cycles keeps the rate legal
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_ff <= 1'b0;
            left_ff  <= 4'h0;
            gap_ff   <= 8'h0;
        end else if (start) begin
            left_ff <= count;
            gap_ff  <= 8'h0;
        end else if (left_ff != 4'h0) begin
            gap_ff <= gap_ff + 8'h1;
            if (gap_ff == 8'(HALF - 1)) begin
                level_ff <= ~level_ff;
                left_ff  <= left_ff - 4'h1;
                gap_ff   <= 8'h0;
            end
        end
    end
    assign pin_level = level_ff;
    assign busy      = (left_ff != 4'h0);
endmodule
`default_nettype wire

// *** verification/rtpc_timer_tb.sv ***
/* Testbench for rtpc_timer: APB tasks, pin source, compares.
   Assumes package, design, checker and pin source compiled first. */
`timescale 1ns/1ps
`default_nettype none
module rtpc_timer_tb;
    import rtpc_pkg::*;
    localparam logic [7:0] CFG = RTPC_OFS_CONFIG, FLG = RTPC_OFS_FLAGS, CNT = RTPC_OFS_CNT_LO, RLD = RTPC_OFS_RLD_LO;
    logic          pclk, presetn, tick, tick_en, pin_evt, irq_ack, src_go, err;
    logic          src_lvl, src_busy, pin_out, pin_oe, pin_wire, t_req, p_req;
    rtpc_apb_req_t apb_req;
    rtpc_apb_rsp_t apb_rsp;
    logic [3:0]    src_cnt;
    logic [1:0]    div;
    logic [31:0]   rd;
    logic [15:0]   v;
    logic [15:0]   rl [2] = '{16'h0000, 16'h0003};
    int            num_errors, tests_run, cycles, n;

    assign pin_wire = pin_oe ? pin_out : src_lvl;
    rtpc_timer u_dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .instruction_cycle_clock(tick), .timer_pin_in(pin_wire), .timer_pin_out(pin_out),
        .timer_pin_oe(pin_oe), .pin_irq_event(pin_evt), .irq_ack(irq_ack),
        .timer_irq_req(t_req), .pin_irq_req(p_req));
    rtpc_pin_source u_src (.pclk(pclk), .presetn(presetn), .start(src_go), .count(src_cnt),
        .pin_level(src_lvl), .busy(src_busy));

    always #5 pclk = ~pclk;
    // One instruction cycle every four pclk
    always @(posedge pclk) begin
        div  <= div + 2'h1;
        tick <= tick_en && (div == 2'h3);
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            num_errors = num_errors + 1;
            final_report();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        apb_req.psel    <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite  <= w;
        apb_req.paddr   <= a;
        apb_req.pwdata  <= d;
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
        rd  = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel    <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(a, 1'b1, {24'h0, d});
    endtask
    task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        chk(name, exp, rd);
    endtask
    task automatic wr16(input logic [7:0] a, input logic [15:0] val);
        wr(a, val[7:0]);
        wr(a + 8'h4, val[15:8]);
    endtask
    // High, low, then high again when the low byte MSB is set
    task automatic rd16(input logic [7:0] a, output logic [15:0] val);
        xfer(a + 8'h4, 1'b0, 32'h0);
        val[15:8] = rd[7:0];
        xfer(a, 1'b0, 32'h0);
        val[7:0] = rd[7:0];
        if (rd[7]) begin
            xfer(a + 8'h4, 1'b0, 32'h0);
            val[15:8] = rd[7:0];
        end
    endtask
    task automatic pin_edges(input logic [3:0] k);
        @(posedge pclk);
        src_go  <= 1'b1;
        src_cnt <= k;
        @(posedge pclk);
        src_go <= 1'b0;
        do @(posedge pclk); while (src_busy);
        repeat (4) @(posedge pclk);
    endtask
    // Ticks between two toggles of the pin
    task automatic period(output int cnt);
        logic last;
        last = pin_out;
        do begin @(posedge pclk); #1; end while (pin_out === last);
        last = pin_out;
        cnt = 0;
        do begin
            @(posedge pclk);
            if (tick) cnt = cnt + 1;
            #1;
        end while (pin_out === last);
    endtask
    task automatic final_report();
        $display("Compares %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        {pclk, presetn, tick, div, pin_evt, irq_ack, src_go, src_cnt} = '0;
        apb_req = '0;
        tick_en = 1'b1;
        {num_errors, tests_run, cycles} = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rdchk("config", CFG, 32'h0);
        rdchk("flags", FLG, 32'h0);
        wr16(RLD, 16'hA55A);
        rd16(RLD, v);
        chk("reload", 32'hA55A, {16'h0, v});
        wr(CFG, 8'h80);
        wr16(CNT, 16'h3CC3);
        rd16(CNT, v);
        chk("stopped count", 32'h3CC3, {16'h0, v});
        wr(8'h40, 8'hFF);
        chk("slverr", 32'h1, {31'h0, err});
        rdchk("unmapped", 8'h40, 32'h0);
        foreach (rl[i]) begin
            wr(CFG, 8'h00);
            wr16(RLD, rl[i]);
            wr16(CNT, 16'h0);
            wr(CFG, 8'hB0);
            // Config lands on the edge that ends the write; let it settle
            #1;
            chk("oe on", 32'h1, {31'h0, pin_oe});
            period(n);
            chk("period", {16'h0, rl[i]} + 32'h1, n);
        end
        wr(CFG, 8'h90);
        wr(FLG, 8'h10);
        chk("oe off", 32'h0, {31'h0, pin_oe});
        repeat (40) @(posedge pclk);
        rdchk("underflow", FLG, 32'h30);
        chk("no global", 32'h0, {31'h0, t_req});
        wr(CFG, 8'h80);
        wr(FLG, 8'h33);
        pin_evt <= 1'b1;
        #1;
        chk("timer req", 32'h1, {31'h0, t_req});
        chk("pin req", 32'h1, {31'h0, p_req});
        @(posedge pclk);
        irq_ack <= 1'b1;
        @(posedge pclk);
        irq_ack <= 1'b0;
        pin_evt <= 1'b0;
        #1;
        chk("acked", 32'h0, {30'h0, t_req, p_req});
        rdchk("ack flags", FLG, 32'h32);
        wr(FLG, 8'h00);
        rdchk("cleared", FLG, 32'h0);
        wr(CFG, 8'h00);
        wr16(RLD, 16'h5);
        wr16(CNT, 16'h1);
        wr(CFG, 8'h10);
        pin_edges(4'h3);
        rd16(CNT, v);
        chk("rising", 32'h5, {16'h0, v});
        rdchk("event flag", FLG, 32'h20);
        wr(CFG, 8'h20);
        wr16(CNT, 16'h5);
        wr(CFG, 8'h30);
        pin_edges(4'h3);
        rd16(CNT, v);
        chk("falling", 32'h3, {16'h0, v});
        tick_en <= 1'b0;
        wr(FLG, 8'h00);
        wr(CFG, 8'hC0);
        wr16(CNT, 16'h1234);
        wr(CFG, 8'hD0);
        pin_edges(4'h1);
        rd16(RLD, v);
        chk("cap rise", 32'h1234, {16'h0, v});
        rdchk("cap flag", FLG, 32'h20);
        wr(CFG, 8'hE0);
        wr16(CNT, 16'h0A5B);
        wr(CFG, 8'hF0);
        pin_edges(4'h1);
        rd16(RLD, v);
        chk("cap fall", 32'h0A5B, {16'h0, v});
        final_report();
    end
endmodule

bind rtpc_timer rtpc_timer_sva u_sva (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .instruction_cycle_clock(instruction_cycle_clock),
    .timer_pin_in(timer_pin_in), .timer_pin_out(timer_pin_out), .timer_pin_oe(timer_pin_oe),
    .pin_irq_event(pin_irq_event), .irq_ack(irq_ack), .timer_irq_req(timer_irq_req),
    .pin_irq_req(pin_irq_req));
`default_nettype wire
